/* File: rtl/dtb_pkg.sv */
// Package: register map, reset values and scan constants of the brightness/test bank
// Behaviour
// - D0 of test register selects test mode
// - Test lights each digit in turn, one per slot, stored registers untouched
// - Test scans eight slots at 7/16 duty
// - Low nibble: digits 0 and 2 duty
// - High nibble: digits 1 and 3 duty
// - Four modulators, sixteen steps, 1/16 blanking
package dtb_pkg;
    localparam logic [7:0] DTB_ADDR_BRT01 = 8'h01;
    localparam logic [7:0] DTB_ADDR_BRT23 = 8'h02;
    localparam logic [7:0] DTB_ADDR_TEST = 8'h07;
    localparam int DTB_TEST_BIT = 0;
    localparam int DTB_LO_NIB = 0;
    localparam int DTB_HI_NIB = 4;
    localparam logic [7:0] DTB_RST_BRT = 8'h00;
    localparam logic DTB_RST_TEST = 1'b0;
    localparam logic [7:0] DTB_RD_UNMAPPED = 8'h00;
    localparam logic [3:0] DTB_TEST_DUTY = 4'h7;
    localparam logic [3:0] DTB_LAST_PHASE = 4'hf;
    localparam int DTB_DIGITS = 4;
    localparam int DTB_TICK_DIV = 4;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } dtb_wr_type;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
    } dtb_rd_type;
endpackage : dtb_pkg

/* File: rtl/dtb_pwm_slice.sv */
// One digit's duty comparator
`timescale 1ns/1ps
module dtb_pwm_slice (
    input wire logic [3:0] level,
    input wire logic [3:0] phase,
    input wire logic test_mode,
    output logic lit
);
    import dtb_pkg::*;
    always_comb begin
        if (test_mode) begin
            lit = (phase < DTB_TEST_DUTY);
        end else begin
            lit = (phase <= level) && (phase != DTB_LAST_PHASE);
        end
    end
endmodule : dtb_pwm_slice

/* File: rtl/dtb_regs.sv */
// Brightness and display-test register bank with per-digit modulators
`timescale 1ns/1ps
module dtb_regs #(
    parameter int TICK_DIV = dtb_pkg::DTB_TICK_DIV
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire dtb_pkg::dtb_wr_type wr,
    input wire dtb_pkg::dtb_rd_type rd,
    input wire logic shutdown,
    input wire logic scan_all,
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    output logic test_mode_q,
    output logic [3:0] drive_q,
    output logic [2:0] slot_q,
    output logic [3:0] phase_q
);
    import dtb_pkg::*;

    logic [7:0] brt01_q, brt01_d, brt23_q, brt23_d;
    logic test_mode_d;
    logic [7:0] rd_data_d;
    logic rd_valid_d;
    logic [$clog2(TICK_DIV+1)-1:0] div_q, div_d;
    logic tick;
    logic [3:0] phase_d;
    logic [2:0] slot_d;
    logic pair_q, pair_d;
    logic [3:0] drive_d;
    logic [3:0] pwm_lit;
    logic [3:0] level [DTB_DIGITS];

    // Register writes and reads
    always_comb begin
        brt01_d = brt01_q;
        brt23_d = brt23_q;
        test_mode_d = test_mode_q;
        rd_valid_d = rd.en;
        rd_data_d = rd_data_q;
        if (wr.en) begin
            case (wr.addr)
                DTB_ADDR_BRT01: brt01_d = wr.data;
                DTB_ADDR_BRT23: brt23_d = wr.data;
                DTB_ADDR_TEST: test_mode_d = wr.data[DTB_TEST_BIT];
                default: ;
            endcase
        end
        if (rd.en) begin
            case (rd.addr)
                DTB_ADDR_BRT01: rd_data_d = brt01_q;
                DTB_ADDR_BRT23: rd_data_d = brt23_q;
                DTB_ADDR_TEST: rd_data_d = {7'h00, test_mode_q};
                default: rd_data_d = DTB_RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            brt01_q <= DTB_RST_BRT;
            brt23_q <= DTB_RST_BRT;
            test_mode_q <= DTB_RST_TEST;
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            brt01_q <= brt01_d;
            brt23_q <= brt23_d;
            test_mode_q <= test_mode_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign level[0] = brt01_q[DTB_LO_NIB +: 4];
    assign level[1] = brt01_q[DTB_HI_NIB +: 4];
    assign level[2] = brt23_q[DTB_LO_NIB +: 4];
    assign level[3] = brt23_q[DTB_HI_NIB +: 4];

    // Scan timing; one phase per tick, sixteen phases per frame
    always_comb begin
        tick = (div_q == ($bits(div_q))'(TICK_DIV - 1));
        div_d = tick ? '0 : div_q + 1'b1;
        phase_d = phase_q;
        slot_d = slot_q;
        pair_d = pair_q;
        if (tick) begin
            phase_d = phase_q + 4'h1;
            if (phase_q == DTB_LAST_PHASE) begin
                slot_d = slot_q + 3'h1;
                pair_d = scan_all ? ~pair_q : 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            div_q <= '0;
            phase_q <= 4'h0;
            slot_q <= 3'h0;
            pair_q <= 1'b0;
        end else begin
            div_q <= div_d;
            phase_q <= phase_d;
            slot_q <= slot_d;
            pair_q <= pair_d;
        end
    end

    for (genvar i = 0; i < DTB_DIGITS; i++) begin : g_pwm
        dtb_pwm_slice u_slice (
            .level(level[i]),
            .phase(phase_q),
            .test_mode(test_mode_q),
            .lit(pwm_lit[i])
        );
    end

    // Digit drive; test ignores shutdown and scan limit
    always_comb begin
        drive_d = 4'h0;
        for (int i = 0; i < DTB_DIGITS; i++) begin
            if (test_mode_q) begin
                drive_d[i] = pwm_lit[i] && (slot_q[1:0] == i[1:0]);
            end else begin
                drive_d[i] = pwm_lit[i] && !shutdown && (pair_q == i[1]);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            drive_q <= 4'h0;
        end else begin
            drive_q <= drive_d;
        end
    end

    a_test_decode: assert property (@(posedge sys_clk) disable iff (srst)
        wr.en && wr.addr == DTB_ADDR_TEST |=> test_mode_q == $past(wr.data[DTB_TEST_BIT]))
        else $error("test mode not taken from D0");

    // upper test bits read as zero
    a_test_readback: assert property (@(posedge sys_clk) disable iff (srst)
        rd.en && rd.addr == DTB_ADDR_TEST
        |=> rd_valid_q && rd_data_q == {7'h00, $past(test_mode_q)})
        else $error("test register read back wrong");

    a_brt_kept: assert property (@(posedge sys_clk) disable iff (srst)
        !(wr.en && (wr.addr == DTB_ADDR_BRT01 || wr.addr == DTB_ADDR_BRT23))
        |=> $stable(brt01_q) && $stable(brt23_q))
        else $error("brightness changed without write");

    a_test_lights: assert property (@(posedge sys_clk) disable iff (srst)
        test_mode_q && shutdown && phase_q < 4'h7 && $stable(test_mode_q)
        |=> drive_q != 4'h0)
        else $error("test mode failed to light a digit");

    a_shut_dark: assert property (@(posedge sys_clk) disable iff (srst)
        !test_mode_q && shutdown |=> drive_q == 4'h0)
        else $error("digit lit in shutdown");

    a_test_duty: assert property (@(posedge sys_clk) disable iff (srst)
        test_mode_q && phase_q >= 4'h7 |=> drive_q == 4'h0)
        else $error("test duty above 7/16");

    // one slot digit at a time
    a_test_single: assert property (@(posedge sys_clk) disable iff (srst)
        test_mode_q |=> $onehot0(drive_q))
        else $error("several digits lit in test");

    a_brt_write: assert property (@(posedge sys_clk) disable iff (srst)
        wr.en && wr.addr == DTB_ADDR_BRT01 |=> brt01_q == $past(wr.data))
        else $error("brightness write lost");

    a_low_nibble: assert property (@(posedge sys_clk) disable iff (srst)
        !test_mode_q && !shutdown && !pair_q && phase_q <= brt01_q[3:0]
        && phase_q != 4'hf |=> drive_q[0])
        else $error("digit 0 duty too short");

    a_digit2_duty: assert property (@(posedge sys_clk) disable iff (srst)
        !test_mode_q && !shutdown && pair_q && phase_q <= brt23_q[3:0]
        && phase_q != DTB_LAST_PHASE |=> drive_q[2])
        else $error("digit 2 duty too short");

    a_high_nibble: assert property (@(posedge sys_clk) disable iff (srst)
        !test_mode_q && !pair_q && phase_q > brt01_q[7:4] |=> !drive_q[1])
        else $error("digit 1 duty too long");

    a_digit3_duty: assert property (@(posedge sys_clk) disable iff (srst)
        !test_mode_q && pair_q && phase_q > brt23_q[7:4] |=> !drive_q[3])
        else $error("digit 3 duty too long");

    a_blank_phase: assert property (@(posedge sys_clk) disable iff (srst)
        phase_q == 4'hf |=> drive_q == 4'h0)
        else $error("no blanking in last phase");

    a_pair_split: assert property (@(posedge sys_clk) disable iff (srst)
        !test_mode_q |=> !((|drive_q[1:0]) && (|drive_q[3:2])))
        else $error("both digit pairs lit");

    a_slot_step: assert property (@(posedge sys_clk) disable iff (srst)
        tick && phase_q == 4'hf |=> slot_q == $past(slot_q) + 3'h1)
        else $error("slot did not advance");

    c_test_enter: cover property (@(posedge sys_clk) disable iff (srst)
        !test_mode_q ##1 test_mode_q);
    c_upper_pair: cover property (@(posedge sys_clk) disable iff (srst)
        pair_q && drive_q[3]);
    c_max_brt: cover property (@(posedge sys_clk) disable iff (srst)
        brt01_q[3:0] == 4'hf && drive_q[0]);
    c_test_shut: cover property (@(posedge sys_clk) disable iff (srst)
        test_mode_q && shutdown && drive_q != 4'h0);
endmodule : dtb_regs

/* File: tb/dtb_host_model.sv */
// Host model: register writes and reads over the strobe port
`timescale 1ns/1ps
module dtb_host_model (
    input wire logic sys_clk,
    output dtb_pkg::dtb_wr_type wr,
    output dtb_pkg::dtb_rd_type rd
);
    import dtb_pkg::*;
    initial begin
        wr = '0;
        rd = '0;
    end
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        wr <= '{w, a, d};
        rd <= '{!w, a};
        @(posedge sys_clk);
        // Stale address must not look valid
        wr <= '{1'b0, ~a, ~d};
        rd <= '{1'b0, ~a};
    endtask : access
endmodule : dtb_host_model

/* File: tb/display_test_and_brightness_regs_test.sv */
// Self-checking bench for the brightness and display-test bank
`timescale 1ns/1ps
module display_test_and_brightness_regs_test;
    import dtb_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic shutdown = 1'b0;
    logic scan_all = 1'b0;
    logic chk_drv = 1'b0;
    logic tst = 1'b0;
    dtb_wr_type wr;
    dtb_rd_type rd;
    logic [7:0] rd_data_q, b01, b23;
    logic rd_valid_q, test_mode_q;
    logic [3:0] drive_q, phase_q, ph_p;
    logic [2:0] slot_q, sl_p;
    logic pr_m = 1'b0;
    logic pr_p = 1'b0;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int n_compared = 0;
    int seed = 32'h9a3b195d;
    always #2.5 sys_clk = ~sys_clk;
    dtb_regs #(.TICK_DIV(1)) dut_u (.sys_clk(sys_clk), .srst(srst), .wr(wr), .rd(rd),
        .shutdown(shutdown), .scan_all(scan_all), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q), .test_mode_q(test_mode_q), .drive_q(drive_q),
        .slot_q(slot_q), .phase_q(phase_q));
    dtb_host_model host_u (.sys_clk(sys_clk), .wr(wr), .rd(rd));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, a, 8'h00);
    endtask : rd_reg
    task automatic watch(input int n);
        repeat (3) @(posedge sys_clk);
        chk_drv <= 1'b1;
        repeat (n) @(posedge sys_clk);
        chk_drv <= 1'b0;
        @(negedge sys_clk);
    endtask : watch
    function automatic logic [3:0] drv_exp(input logic [3:0] ph, input logic [2:0] sl,
        input logic pr);
        logic [3:0] e;
        e = 4'h0;
        if (tst) begin
            e = (ph < DTB_TEST_DUTY) ? 4'h1 << sl[1:0] : 4'h0;
        end else if (!shutdown && ph != DTB_LAST_PHASE) begin
            // Digits 0,1 share a frame, digits 2,3 the other
            e[0] = !pr && ph <= b01[3:0];
            e[1] = !pr && ph <= b01[7:4];
            e[2] = pr && ph <= b23[3:0];
            e[3] = pr && ph <= b23[7:4];
        end
        return e;
    endfunction : drv_exp
    always @(posedge sys_clk) begin
        if (rd_valid_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("spurious read", 8'h01, 8'h00);
            end else begin
                check("read data", rd_data_q, exp_q.pop_front());
            end
        end
        if (chk_drv) begin
            check("drive", {4'h0, drive_q}, {4'h0, drv_exp(ph_p, sl_p, pr_p)});
            check("phase step", {4'h0, phase_q}, {4'h0, ph_p + 4'h1});
            check("slot step", {5'h0, slot_q},
                {5'h0, (ph_p == DTB_LAST_PHASE) ? sl_p + 3'h1 : sl_p});
        end
        ph_p = phase_q;
        sl_p = slot_q;
        // Pair model assumes one phase per clock (TICK_DIV of 1)
        pr_p = pr_m;
        if (srst) begin
            pr_m = 1'b0;
        end else if (phase_q == DTB_LAST_PHASE) begin
            pr_m = scan_all ? ~pr_m : 1'b0;
        end
    end
    task automatic wrap_up();
        check("reads left", 8'(exp_q.size()), 8'h00);
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        #25000;
        err_count++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        rd_reg(DTB_ADDR_BRT01, DTB_RST_BRT);
        rd_reg(DTB_ADDR_TEST, 8'h00);
        for (int i = 0; i < 4; i++) begin
            b01 = (i == 0) ? 8'h0f : 8'($random(seed));
            b23 = 8'($random(seed));
            host_u.access(1'b1, DTB_ADDR_BRT01, b01);
            host_u.access(1'b1, DTB_ADDR_BRT23, b23);
            host_u.access(1'b1, 8'h03, 8'hff);
            rd_reg(DTB_ADDR_BRT23, b23);
            rd_reg(8'h03, DTB_RD_UNMAPPED);
            shutdown <= (i == 3);
            // Upper digit pair only scanned with scan_all
            scan_all <= (i >= 2);
            watch(40);
        end
        $display("brightness test done");
        host_u.access(1'b1, DTB_ADDR_TEST, 8'h81);
        scan_all <= 1'b1;
        @(negedge sys_clk);
        check("test set", {7'h0, test_mode_q}, 8'h01);
        host_u.access(1'b1, DTB_ADDR_TEST, 8'hfe);
        @(negedge sys_clk);
        check("test clear", {7'h0, test_mode_q}, 8'h00);
        host_u.access(1'b1, DTB_ADDR_TEST, 8'h01);
        @(negedge sys_clk);
        check("test set again", {7'h0, test_mode_q}, 8'h01);
        tst = 1'b1;
        watch(140);
        rd_reg(DTB_ADDR_TEST, 8'h01);
        rd_reg(DTB_ADDR_BRT01, b01);
        rd_reg(DTB_ADDR_BRT23, b23);
        host_u.access(1'b1, DTB_ADDR_TEST, 8'h00);
        tst = 1'b0;
        scan_all <= 1'b0;
        shutdown <= 1'b0;
        watch(40);
        $display("display test done");
        // Mid-run reset must restore the reset values
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rd_reg(DTB_ADDR_BRT01, DTB_RST_BRT);
        rd_reg(DTB_ADDR_BRT23, DTB_RST_BRT);
        rd_reg(DTB_ADDR_TEST, {7'h00, DTB_RST_TEST});
        // Let the last read answer before closing
        repeat (2) @(posedge sys_clk);
        $display("reset test done");
        wrap_up();
    end
endmodule : display_test_and_brightness_regs_test
